// file: verilog/aoup_pkg.sv
// aoup_pkg: offsets, field positions, reset values and states of the output path
package aoup_pkg;
   localparam int IO_ADDR_W = 10;
   localparam int OFF_W = 5;
   localparam logic [OFF_W-1:0] OFF_SEL = 5'h00;
   localparam logic [OFF_W-1:0] OFF_WDATA = 5'h02;
   localparam logic [OFF_W-1:0] OFF_STATUS = 5'h06;
   localparam logic [OFF_W-1:0] OFF_CFG = 5'h16;
   localparam logic [OFF_W-1:0] OFF_DIR0 = 5'h18;
   localparam logic [OFF_W-1:0] OFF_DIR1 = 5'h1A;
   localparam logic [OFF_W-1:0] OFF_QUEUE = 5'h1E;
   // indirect register numbers behind the window
   localparam logic [15:0] IX_MODE = 16'h0000;
   localparam logic [15:0] IX_UI_LO = 16'h0001;
   localparam logic [15:0] IX_UI_HI = 16'h0002;
   localparam logic [15:0] IX_UC_LO = 16'h0003;
   localparam logic [15:0] IX_UC_HI = 16'h0004;
   localparam logic [15:0] IX_BC = 16'h0005;
   localparam logic [15:0] IX_CMD = 16'h0006;
   localparam int MODE_TIMED0 = 0;
   localparam int MODE_TIMED1 = 1;
   localparam int MODE_ILV = 2;
   localparam int MODE_RETX = 3;
   localparam int MODE_VIRT = 4;
   localparam int MODE_DST = 5;
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int CMD_UPD0 = 2;
   localparam int CMD_UPD1 = 3;
   localparam int CMD_CLR = 4;
   localparam int CFG_BIP = 0;
   localparam int CFG_EXT = 1;
   localparam int CFG_RGL = 2;
   localparam int CFG_CH_STRIDE = 3;
   localparam int STB_EMPTY = 0;
   localparam int STB_HALF = 1;
   localparam int STB_FULL = 2;
   localparam int STB_RUN = 3;
   localparam int STB_STALL = 4;
   localparam logic [15:0] SEL_RST = 16'h0000;
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [23:0] UI_RST = 24'h000001;
   localparam logic [23:0] UC_RST = 24'h000001;
   localparam logic [15:0] BC_RST = 16'h0001;
   localparam logic [1:0] NEED_ONE = 2'h1;
   localparam logic [1:0] NEED_TWO = 2'h2;
   typedef enum logic [1:0] {
      AOUP_IDLE = 2'b01,
      AOUP_RUN = 2'b10
   } aoup_state_e;
endpackage : aoup_pkg

// file: verilog/aoup_fifo.sv
// aoup_fifo: output sample queue with retransmit replay
`timescale 1ns/100ps
`default_nettype none
module aoup_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk_i, // board clock
   input wire logic rst_i, // sync reset, high
   input wire logic clear_i, // drop all contents
   input wire logic retx_i, // keep data for replay
   input wire logic in_valid_i, // write offered
   output logic in_ready_o, // room for a write
   input wire logic [WIDTH-1:0] in_data_i, // write word
   output logic out_valid_o, // word available
   input wire logic out_ready_i, // consumer takes word
   output logic [WIDTH-1:0] out_data_o, // oldest word
   output logic [$clog2(DEPTH):0] count_o // words readable
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, loaded, next_count, next_loaded;
   logic push, pop, restore;

   // loaded counts every word still owned; in replay mode pops do not free
   assign in_ready_o = loaded < DEPTH_C;
   assign out_valid_o = count != '0;
   assign out_data_o = mem[rd_ptr];
   assign count_o = count;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   // replay runs out: rewind to the first word loaded
   assign restore = retx_i && !push && loaded != '0 &&
                    (count == '0 || (pop && count == (AW+1)'(1)));

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      next_loaded = loaded;
      if (clear_i) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count = '0;
         next_loaded = '0;
      end else if (restore) begin
         next_rd_ptr = wr_ptr - loaded[AW-1:0];
         next_count = loaded;
      end else begin
         if (push) begin
            next_wr_ptr = wr_ptr + 1'b1;
         end
         if (pop) begin
            next_rd_ptr = rd_ptr + 1'b1;
         end
         next_count = count + (AW+1)'(push) - (AW+1)'(pop);
         next_loaded = loaded + (AW+1)'(push) - (AW+1)'(pop && !retx_i);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         loaded <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         loaded <= next_loaded;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (push && !clear_i) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   property p_full_blocks;
      @(posedge ref_clk_i) disable iff (rst_i)
      in_valid_i && !in_ready_o && !clear_i && !out_ready_i
      |=> loaded == $past(loaded);
   endproperty
   a_full_blocks: assert property (p_full_blocks)
      else $error("write into full queue changed its fill");

   property p_replay;
      @(posedge ref_clk_i) disable iff (rst_i)
      retx_i && count == '0 && loaded != '0 && !clear_i && !in_valid_i
      |=> count == $past(loaded);
   endproperty
   a_replay: assert property (p_replay)
      else $error("empty replay queue was not restored");
endmodule : aoup_fifo
`default_nettype wire

// file: verilog/aoup_top.sv
// aoup_top: analog output data path, direct and timed DAC updating
`timescale 1ns/100ps
`default_nettype none
//Contract
// - direct write loads channel input stage
// - immediate mode passes direct write to output
// - timed mode output waits for update strobe
// - 24-bit interval counter makes update pulses
// - 24-bit update counter sets buffer length
// - buffer counter repeats buffer, ends sequence
// - each update fetches next word from queue
// - queue written when not full, read nonempty
// - empty queue stalls transfer until host writes
// - virtual mode clears full flag per update
// - virtual mode forwards word, stores nothing
// - full flag set again after forwarding
// - replay restores queue contents when empty
// - two-channel data alternates between DACs
// - registers decoded at base plus offset
// - indirect registers through select then data
// - immediate bypasses double buffer, timed keeps it
// - polarity, reference, reglitch from configuration
// - unipolar straight binary, bipolar two's complement
module aoup_top
   import aoup_pkg::*;
#(
   parameter int DAC_W = 12,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic ref_clk_i, // 40 MHz board clock
   input wire logic rst_i, // sync reset, high
   input wire logic [IO_ADDR_W-1:0] base_addr_i, // board base address
   input wire logic [IO_ADDR_W-1:0] io_addr_i, // host I/O address
   input wire logic [15:0] io_wdata_i, // host write data
   input wire logic io_wr_i, // host write strobe
   input wire logic io_rd_i, // host read strobe
   output logic [15:0] io_rdata_o, // host read data
   output logic queue_ready_o, // queue can take a word
   output logic vfifo_full_o, // virtual full flag
   output logic running_o, // sequence active
   output logic update_pulse_o, // interval tick
   output logic [DAC_W-1:0] ch0_input_stage_o, // first buffer, ch0
   output logic [DAC_W-1:0] ch1_input_stage_o, // first buffer, ch1
   output logic [DAC_W-1:0] ch0_dac_code_o, // DAC output latch, ch0
   output logic [DAC_W-1:0] ch1_dac_code_o, // DAC output latch, ch1
   output logic channel0_update_strobe_n_o, // ch0 update, low
   output logic channel1_update_strobe_n_o, // ch1 update, low
   output logic [1:0] bipolar_o, // per channel polarity
   output logic [1:0] ext_ref_o, // per channel reference
   output logic [1:0] reglitch_o // per channel reglitch
);
   localparam int CW = $clog2(FIFO_DEPTH);
   localparam logic [CW:0] HALF = (CW+1)'(FIFO_DEPTH / 2);

   // bipolar two's complement turns offset binary for the converter
   function automatic logic [DAC_W-1:0] to_code(input logic [15:0] v,
                                                  input logic bip);
      logic [DAC_W-1:0] c;
      c = v[DAC_W-1:0];
      if (bip) begin
         c[DAC_W-1] = ~c[DAC_W-1];
      end
      return c;
   endfunction : to_code

   aoup_state_e state, next_state;
   logic [15:0] sel, mode, cfg, next_sel, next_mode, next_cfg;
   logic [23:0] ui_load, uc_load, next_ui_load, next_uc_load;
   logic [15:0] bc_load, next_bc_load;
   logic [23:0] ui_cnt, uc_cnt, next_ui_cnt, next_uc_cnt;
   logic [15:0] bc_cnt, next_bc_cnt;
   logic [1:0] need, next_need;
   logic dst, next_dst, vfull, next_vfull;
   logic str0, str1, next_str0, next_str1;
   logic [DAC_W-1:0] in0, in1, out0, out1;
   logic [DAC_W-1:0] next_in0, next_in1, next_out0, next_out1;
   logic [15:0] rdata, next_rdata, status;
   logic hit, wr_sel, wr_win, wr_cfg, wr_dir0, wr_dir1, wr_q;
   logic [OFF_W-1:0] off;
   logic start, stop, sw_upd0, sw_upd1, q_clear;
   logic upd, last_upd, pop, fwd, xfer, stall;
   logic [15:0] xfer_word;
   logic q_valid, q_ready, q_push;
   logic [15:0] q_data;
   logic [CW:0] q_count;
   logic [DAC_W-1:0] dir0_code, dir1_code;

   // 32-byte block at the board base
   assign hit = io_addr_i[IO_ADDR_W-1:OFF_W] ==
                base_addr_i[IO_ADDR_W-1:OFF_W];
   assign off = io_addr_i[OFF_W-1:0];
   assign wr_sel = io_wr_i && hit && off == OFF_SEL;
   assign wr_win = io_wr_i && hit && off == OFF_WDATA;
   assign wr_cfg = io_wr_i && hit && off == OFF_CFG;
   assign wr_dir0 = io_wr_i && hit && off == OFF_DIR0;
   assign wr_dir1 = io_wr_i && hit && off == OFF_DIR1;
   assign wr_q = io_wr_i && hit && off == OFF_QUEUE;
   assign start = wr_win && sel == IX_CMD && io_wdata_i[CMD_START];
   assign stop = wr_win && sel == IX_CMD && io_wdata_i[CMD_STOP];
   assign sw_upd0 = wr_win && sel == IX_CMD && io_wdata_i[CMD_UPD0];
   assign sw_upd1 = wr_win && sel == IX_CMD && io_wdata_i[CMD_UPD1];
   assign q_clear = wr_win && sel == IX_CMD && io_wdata_i[CMD_CLR];
   assign dir0_code = to_code(io_wdata_i, cfg[CFG_BIP]);
   assign dir1_code = to_code(io_wdata_i, cfg[CFG_CH_STRIDE+CFG_BIP]);

   // an interval load of one ticks every cycle
   assign upd = state == AOUP_RUN && ui_cnt == '0;
   assign last_upd = upd && uc_cnt <= 24'h000001 &&
                     bc_cnt <= 16'h0001;
   assign pop = state == AOUP_RUN && need != '0 && !mode[MODE_VIRT] &&
                q_valid;
   assign fwd = wr_q && mode[MODE_VIRT] && !vfull;
   assign xfer = pop || fwd;
   assign xfer_word = pop ? q_data : io_wdata_i;
   assign stall = state == AOUP_RUN && need != '0 && !mode[MODE_VIRT] &&
                  !q_valid;
   // the virtual path never enters the queue
   assign q_push = wr_q && !mode[MODE_VIRT];

   aoup_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .clear_i(q_clear),
      .retx_i(mode[MODE_RETX]),
      .in_valid_i(q_push),
      .in_ready_o(q_ready),
      .in_data_i(io_wdata_i),
      .out_valid_o(q_valid),
      .out_ready_i(pop),
      .out_data_o(q_data),
      .count_o(q_count)
   );

   always_comb begin
      status = 16'h0000;
      status[STB_EMPTY] = q_count == '0;
      status[STB_HALF] = q_count >= HALF;
      status[STB_FULL] = mode[MODE_VIRT] ? vfull : !q_ready;
      status[STB_RUN] = state == AOUP_RUN;
      status[STB_STALL] = stall;
   end

   always_comb begin
      next_sel = sel;
      next_mode = mode;
      next_cfg = cfg;
      next_ui_load = ui_load;
      next_uc_load = uc_load;
      next_bc_load = bc_load;
      next_rdata = rdata;
      if (wr_sel) begin
         next_sel = io_wdata_i;
      end
      if (wr_cfg) begin
         next_cfg = io_wdata_i;
      end
      if (wr_win) begin
         unique case (sel)
            IX_MODE: next_mode = io_wdata_i;
            IX_UI_LO: next_ui_load[15:0] = io_wdata_i;
            IX_UI_HI: next_ui_load[23:16] = io_wdata_i[7:0];
            IX_UC_LO: next_uc_load[15:0] = io_wdata_i;
            IX_UC_HI: next_uc_load[23:16] = io_wdata_i[7:0];
            IX_BC: next_bc_load = io_wdata_i;
            default: next_rdata = rdata;
         endcase
      end
      if (io_rd_i) begin
         if (hit && off == OFF_SEL) begin
            next_rdata = sel;
         end else if (hit && off == OFF_STATUS) begin
            next_rdata = status;
         end else begin
            next_rdata = 16'h0000;
         end
      end
   end

   always_comb begin
      next_state = state;
      next_ui_cnt = ui_cnt;
      next_uc_cnt = uc_cnt;
      next_bc_cnt = bc_cnt;
      next_need = need;
      next_dst = dst;
      next_vfull = vfull;
      next_in0 = in0;
      next_in1 = in1;
      next_out0 = out0;
      next_out1 = out1;
      // interval strobes only reach channels held in timed mode; software strobes reach either channel
      next_str0 = (upd && mode[MODE_TIMED0]) || sw_upd0;
      next_str1 = (upd && mode[MODE_TIMED1]) || sw_upd1;
      if (str0) begin
         next_out0 = in0;
      end
      if (str1) begin
         next_out1 = in1;
      end
      // transfer of the next word into the selected first buffer
      if (xfer) begin
         if (!dst) begin
            next_in0 = to_code(xfer_word, cfg[CFG_BIP]);
            if (!mode[MODE_TIMED0]) begin
               next_out0 = next_in0;
            end
         end else begin
            next_in1 = to_code(xfer_word, cfg[CFG_CH_STRIDE+CFG_BIP]);
            if (!mode[MODE_TIMED1]) begin
               next_out1 = next_in1;
            end
         end
         next_need = need - 2'h1;
         if (mode[MODE_ILV]) begin
            next_dst = !dst;
         end
         if (fwd && need == NEED_ONE) begin
            next_vfull = 1'b1;
         end
      end
      // a direct write takes the first buffer over a transfer
      if (wr_dir0) begin
         next_in0 = dir0_code;
         if (!mode[MODE_TIMED0]) begin
            next_out0 = dir0_code;
         end
      end
      if (wr_dir1) begin
         next_in1 = dir1_code;
         if (!mode[MODE_TIMED1]) begin
            next_out1 = dir1_code;
         end
      end
      unique case (state)
         AOUP_IDLE: begin
            if (start) begin
               next_state = AOUP_RUN;
               next_ui_cnt = ui_load - 24'h000001;
               next_uc_cnt = uc_load;
               next_bc_cnt = bc_load;
               // prime the first buffer before the first tick
               next_need = mode[MODE_ILV] ? NEED_TWO : NEED_ONE;
               next_dst = mode[MODE_ILV] ? 1'b0 : mode[MODE_DST];
               next_vfull = !mode[MODE_VIRT];
            end
         end
         AOUP_RUN: begin
            if (stop) begin
               next_state = AOUP_IDLE;
               next_need = '0;
               next_vfull = 1'b1;
            end else if (upd) begin
               next_ui_cnt = ui_load - 24'h000001;
               if (last_upd) begin
                  next_state = AOUP_IDLE;
                  next_need = '0;
                  next_vfull = 1'b1;
               end else begin
                  if (uc_cnt <= 24'h000001) begin
                     next_uc_cnt = uc_load;
                     next_bc_cnt = bc_cnt - 16'h0001;
                  end else begin
                     next_uc_cnt = uc_cnt - 24'h000001;
                  end
                  // words not yet delivered are skipped, not queued
                  next_need = mode[MODE_ILV] ? NEED_TWO : NEED_ONE;
                  next_dst = mode[MODE_ILV] ? 1'b0 : mode[MODE_DST];
                  if (mode[MODE_VIRT]) begin
                     next_vfull = 1'b0;
                  end
               end
            end else begin
               next_ui_cnt = ui_cnt - 24'h000001;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sel <= SEL_RST;
         mode <= MODE_RST;
         cfg <= CFG_RST;
         ui_load <= UI_RST;
         uc_load <= UC_RST;
         bc_load <= BC_RST;
         rdata <= 16'h0000;
         state <= AOUP_IDLE;
         ui_cnt <= '0;
         uc_cnt <= '0;
         bc_cnt <= '0;
         need <= '0;
         dst <= 1'b0;
         vfull <= 1'b1;
         str0 <= 1'b0;
         str1 <= 1'b0;
         in0 <= '0;
         in1 <= '0;
         out0 <= '0;
         out1 <= '0;
      end else begin
         sel <= next_sel;
         mode <= next_mode;
         cfg <= next_cfg;
         ui_load <= next_ui_load;
         uc_load <= next_uc_load;
         bc_load <= next_bc_load;
         rdata <= next_rdata;
         state <= next_state;
         ui_cnt <= next_ui_cnt;
         uc_cnt <= next_uc_cnt;
         bc_cnt <= next_bc_cnt;
         need <= next_need;
         dst <= next_dst;
         vfull <= next_vfull;
         str0 <= next_str0;
         str1 <= next_str1;
         in0 <= next_in0;
         in1 <= next_in1;
         out0 <= next_out0;
         out1 <= next_out1;
      end
   end

   assign io_rdata_o = rdata;
   assign queue_ready_o = q_ready;
   assign vfifo_full_o = vfull;
   assign running_o = state == AOUP_RUN;
   assign update_pulse_o = upd;
   assign ch0_input_stage_o = in0;
   assign ch1_input_stage_o = in1;
   assign ch0_dac_code_o = out0;
   assign ch1_dac_code_o = out1;
   assign channel0_update_strobe_n_o = !str0;
   assign channel1_update_strobe_n_o = !str1;
   assign bipolar_o = {cfg[CFG_CH_STRIDE+CFG_BIP], cfg[CFG_BIP]};
   assign ext_ref_o = {cfg[CFG_CH_STRIDE+CFG_EXT], cfg[CFG_EXT]};
   assign reglitch_o = {cfg[CFG_CH_STRIDE+CFG_RGL], cfg[CFG_RGL]};

   property p_direct_load;
      @(posedge ref_clk_i) disable iff (rst_i)
      wr_dir0 |=> in0 == $past(dir0_code);
   endproperty
   a_direct_load: assert property (p_direct_load)
      else $error("direct write missed channel 0 input stage");

   property p_immediate;
      @(posedge ref_clk_i) disable iff (rst_i)
      wr_dir1 && !mode[MODE_TIMED1] |=> out1 == $past(dir1_code);
   endproperty
   a_immediate: assert property (p_immediate)
      else $error("immediate write did not reach channel 1 output");

   property p_timed_hold;
      @(posedge ref_clk_i) disable iff (rst_i)
      wr_dir0 && mode[MODE_TIMED0] && !str0 |=> $stable(out0);
   endproperty
   a_timed_hold: assert property (p_timed_hold)
      else $error("timed channel output changed on a data write");

   property p_strobe_load;
      @(posedge ref_clk_i) disable iff (rst_i)
      !channel0_update_strobe_n_o |=> out0 == $past(in0);
   endproperty
   a_strobe_load: assert property (p_strobe_load)
      else $error("update strobe did not load channel 0 output");

   property p_interval;
      @(posedge ref_clk_i) disable iff (rst_i)
      upd && !stop && !last_upd ##1 ui_load == $past(ui_load)
      |-> ui_cnt == ui_load - 24'h000001;
   endproperty
   a_interval: assert property (p_interval)
      else $error("interval counter not reloaded after tick");

   property p_start_load;
      @(posedge ref_clk_i) disable iff (rst_i)
      state == AOUP_IDLE && start
      |=> uc_cnt == $past(uc_load) && bc_cnt == $past(bc_load);
   endproperty
   a_start_load: assert property (p_start_load)
      else $error("update or buffer counter not loaded at start");

   property p_sequence_end;
      @(posedge ref_clk_i) disable iff (rst_i)
      last_upd && !stop |=> state == AOUP_IDLE && need == '0;
   endproperty
   a_sequence_end: assert property (p_sequence_end)
      else $error("sequence did not end on its final update");

   property p_stall;
      @(posedge ref_clk_i) disable iff (rst_i)
      stall && !wr_dir0 && !dst |=> $stable(in0);
   endproperty
   a_stall: assert property (p_stall)
      else $error("transfer happened from an empty queue");

   property p_vclear;
      @(posedge ref_clk_i) disable iff (rst_i)
      upd && mode[MODE_VIRT] && !last_upd && !stop |=> !vfull;
   endproperty
   a_vclear: assert property (p_vclear)
      else $error("virtual full flag not cleared on update");

   property p_vset;
      @(posedge ref_clk_i) disable iff (rst_i)
      fwd && need == NEED_ONE && !upd |=> vfull;
   endproperty
   a_vset: assert property (p_vset)
      else $error("virtual full flag not set after forwarding");

   property p_alternate;
      @(posedge ref_clk_i) disable iff (rst_i)
      pop && mode[MODE_ILV] && !dst && !upd && !start |=> dst;
   endproperty
   a_alternate: assert property (p_alternate)
      else $error("interleaved transfer did not move to channel 1");

   property p_reset_state;
      @(posedge ref_clk_i) disable iff (rst_i)
      $past(rst_i) |-> vfull && state == AOUP_IDLE && q_count == '0;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("state after reset is not empty and idle");
endmodule : aoup_top
`default_nettype wire

// file: test/aoup_host_model.sv
// aoup_host_model: host software side of the I/O bus
`timescale 1ns/100ps
`default_nettype none
module aoup_host_model
   import aoup_pkg::*;
#(
   parameter logic [IO_ADDR_W-1:0] BASE = 10'h120
) (
   input wire logic clk_i, // board clock
   input wire logic [15:0] rdata_i, // read data
   input wire logic ready_i, // queue has room
   output logic [IO_ADDR_W-1:0] addr_o, // I/O address
   output logic [15:0] wdata_o, // write data
   output logic wr_o, // write strobe
   output logic rd_o // read strobe
);
   // pacing waits that ran out, folded into the mismatch count
   int stuck = 0;
   initial begin
      addr_o = '0;
      wdata_o = '0;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   task automatic wr(input logic [IO_ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      // released bus shows junk, never the last value
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask : wr
   task automatic rd(input logic [IO_ADDR_W-1:0] a, output logic [15:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      repeat (2) @(posedge clk_i);
      d = rdata_i;
   endtask : rd
   // select first, then data
   task automatic ix(input logic [15:0] idx, input logic [15:0] d);
      wr(BASE | {5'h00, OFF_SEL}, idx);
      wr(BASE | {5'h00, OFF_WDATA}, d);
   endtask : ix
   // pacing on not-full only, half and empty flags unused
   task automatic push(input logic [15:0] d);
      for (int i = 0; i < 64 && ready_i !== 1'b1; i++) @(posedge clk_i);
      if (ready_i !== 1'b1) stuck++;
      wr(BASE | {5'h00, OFF_QUEUE}, d);
   endtask : push
endmodule : aoup_host_model
`default_nettype wire

// file: test/analog_output_update_path_tb_top.sv
// analog_output_update_path_tb_top: directed register-level tests
`timescale 1ns/100ps
`default_nettype none
module analog_output_update_path_tb_top
   import aoup_pkg::*;
;
   localparam logic [IO_ADDR_W-1:0] BASE = 10'h120;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [IO_ADDR_W-1:0] addr;
   logic [15:0] wdata, rdata, rv;
   logic wr, rd, qrdy, vfull, run;
   logic [11:0] in0, in1, dac0, dac1;
   logic [1:0] bip;
   int fail_count = 0;
   int compares = 0;
   always #12.5 ref_clk = ~ref_clk;
   aoup_host_model #(.BASE(BASE)) host (.clk_i(ref_clk), .rdata_i(rdata),
      .ready_i(qrdy), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   aoup_top #(.DAC_W(12), .FIFO_DEPTH(16)) dut (.ref_clk_i(ref_clk),
      .rst_i(rst), .base_addr_i(BASE), .io_addr_i(addr), .io_wdata_i(wdata),
      .io_wr_i(wr), .io_rd_i(rd), .io_rdata_o(rdata), .queue_ready_o(qrdy),
      .vfifo_full_o(vfull), .running_o(run), .update_pulse_o(),
      .ch0_input_stage_o(in0), .ch1_input_stage_o(in1),
      .ch0_dac_code_o(dac0), .ch1_dac_code_o(dac1),
      .channel0_update_strobe_n_o(), .channel1_update_strobe_n_o(),
      .bipolar_o(bip), .ext_ref_o(), .reglitch_o());
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic settle;
      @(posedge ref_clk);
      #1;
   endtask : settle
   task automatic give_verdict;
      fail_count += host.stuck;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      host.rd(BASE | 10'h006, rv);
      chk("status", 16'h0001, rv);
      chk("vfull", 16'h0001, 16'(vfull));
      $display("test reset done");
      host.wr(BASE | 10'h018, 16'h0ABC);
      host.wr(10'h01A, 16'h0555);
      settle;
      chk("in0", 16'h0ABC, 16'(in0));
      chk("dac0", 16'h0ABC, 16'(dac0));
      chk("in1 foreign base", 16'h0000, 16'(in1));
      $display("test direct done");
      host.ix(IX_MODE, 16'h0002);
      host.wr(BASE | 10'h01A, 16'h0123);
      settle;
      chk("in1", 16'h0123, 16'(in1));
      chk("dac1 held", 16'h0000, 16'(dac1));
      host.ix(IX_CMD, 16'h0008);
      repeat (3) settle;
      chk("dac1 strobed", 16'h0123, 16'(dac1));
      host.wr(BASE | 10'h016, 16'h0008);
      host.wr(BASE | 10'h01A, 16'h0800);
      settle;
      chk("bip", 16'h0002, 16'(bip));
      chk("in1 bipolar", 16'h0000, 16'(in1));
      $display("test timed done");
      host.wr(BASE | 10'h016, 16'h0000);
      host.ix(IX_MODE, 16'h0001);
      host.ix(IX_UI_LO, 16'h0003);
      host.ix(IX_UC_LO, 16'h0002);
      host.push(16'h0111);
      host.push(16'h0222);
      host.ix(IX_CMD, 16'h0001);
      repeat (2) settle;
      // two updates of three cycles each, generous bound
      for (int i = 0; i < 200 && run !== 1'b0; i++) settle;
      if (run !== 1'b0) begin
         fail_count++;
      end
      // final strobe reaches the output latch a cycle after idle
      settle;
      chk("dac0 last", 16'h0222, 16'(dac0));
      chk("queue ready", 16'h0001, 16'(qrdy));
      $display("test sequence done");
      host.ix(IX_MODE, 16'h0014);
      host.ix(IX_UI_LO, 16'h0100);
      host.ix(IX_CMD, 16'h0001);
      settle;
      chk("vfull armed", 16'h0000, 16'(vfull));
      host.push(16'h0333);
      host.push(16'h0444);
      settle;
      chk("dac0 virtual", 16'h0333, 16'(dac0));
      chk("dac1 virtual", 16'h0444, 16'(dac1));
      chk("vfull set", 16'h0001, 16'(vfull));
      host.rd(BASE | 10'h006, rv);
      chk("status virtual", 16'h000D, rv);
      $display("test virtual done");
      give_verdict;
   end
endmodule : analog_output_update_path_tb_top
`default_nettype wire
